// [design/i2c_target_unit.sv]
`timescale 1ns/1ps
`include "i2c_link_consts.svh"
module i2c_target_unit #(
  parameter int CNT_W = `CNT_W,
  parameter int PTR_W = `PTR_W
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Configuration
  input wire logic i_enable,
  input wire logic [1:0] i_addr_cfg,
  input wire logic [`ADDR_W-1:0] i_addr0,
  input wire logic [`ADDR_W-1:0] i_addr1,
  input wire logic [PTR_W-1:0] i_tx_buffer_pointer,
  input wire logic [CNT_W-1:0] i_tx_byte_limit,
  input wire logic [7:0] i_overread_fill_byte,
  // Tasks
  input wire logic i_tx_arm_task,
  input wire logic i_stop_task,
  // Events and status
  output logic o_read_event,
  output logic o_transmit_begun_event,
  output logic o_stopped_event,
  output logic o_error_event,
  output logic [CNT_W-1:0] o_tx_bytes_sent_count,
  // DMA reader
  output logic o_dma_req,
  output logic [PTR_W-1:0] o_dma_addr,
  input wire logic i_dma_ack,
  input wire logic [7:0] i_dma_rdata,
  // Link
  i2c_link_if.target link
);
  import i2c_link_pkg::*;

  // ****************************************
  // Parameter checks
  // ****************************************
  generate
    if (CNT_W < 1 || PTR_W < CNT_W) begin : g_bad
      $error("i2c_target_unit: unsupported widths");
    end
  endgenerate

  tgt_state_t state_r;
  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic armed_r, arm_clr;
  logic [7:0] sh_r;
  logic [3:0] bit_cnt_r;
  logic mack_r;
  logic [PTR_W-1:0] ptr_r;
  logic [CNT_W-1:0] lim_r;
  logic [CNT_W-1:0] cnt_r;
  logic addr_hit;
  logic scl_oe_r, sda_oe_r;

  // ****************************************
  // Pin synchronisers and condition detect
  // ****************************************
  // Two flops, then a delayed copy for edges
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      {scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r} <= 6'H3F;
    end else begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= {link.scl, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_d_r} <= {link.sda, sda_s1_r, sda_s2_r};
    end
  end

  // Edges and start/stop conditions
  assign scl_rise = scl_s2_r && !scl_d_r;
  assign scl_fall = !scl_s2_r && scl_d_r;
  assign start_det = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
  assign stop_det = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;

  // Address match against enabled slots
  assign addr_hit = (i_addr_cfg[`CFG_ADDR0_BIT] && sh_r[7:1] == i_addr0) ||
                    (i_addr_cfg[`CFG_ADDR1_BIT] && sh_r[7:1] == i_addr1);

  // ****************************************
  // Armed flag
  // ****************************************
  // Set by task wins over any clear
  assign arm_clr = o_transmit_begun_event || o_stopped_event;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      armed_r <= 1'B0;
    end else if (i_tx_arm_task) begin
      armed_r <= 1'B1;
    end else if (arm_clr) begin
      armed_r <= 1'B0;
    end
  end

  // ****************************************
  // DMA reader request
  // ****************************************
  // Request held until acknowledged
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_dma_req <= 1'B0;
      o_dma_addr <= `PTR_RST;
    end else if (o_dma_req) begin
      if (i_dma_ack) begin
        o_dma_req <= 1'B0;
      end
    end else if (state_r == T_FETCH && cnt_r < lim_r && !stop_det && !i_stop_task) begin
      o_dma_req <= 1'B1;
      o_dma_addr <= ptr_r + PTR_W'(cnt_r);
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Bus protocol, stretching and events
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || !i_enable) begin
      state_r <= T_IDLE;
      scl_oe_r <= 1'B0;
      sda_oe_r <= 1'B0;
      sh_r <= 8'H00;
      bit_cnt_r <= 4'H0;
      mack_r <= `NACK_BIT;
      ptr_r <= `PTR_RST;
      lim_r <= `CNT_RST;
      cnt_r <= i_reset ? `CNT_RST : cnt_r;
      {o_read_event, o_transmit_begun_event, o_stopped_event, o_error_event} <= 4'H0;
    end else begin
      {o_read_event, o_transmit_begun_event, o_stopped_event, o_error_event} <= 4'H0;
      if (i_stop_task || (stop_det && state_r != T_IDLE && state_r != T_ADDR)) begin
        state_r <= T_STOPPING;
        scl_oe_r <= 1'B0;
        sda_oe_r <= 1'B0;
      end else if (stop_det) begin
        state_r <= T_IDLE;
        sda_oe_r <= 1'B0;
      end else if (start_det && state_r != T_STOPPING) begin
        // Restart goes straight to the address phase
        state_r <= T_ADDR;
        bit_cnt_r <= 4'H0;
        scl_oe_r <= 1'B0;
        sda_oe_r <= 1'B0;
      end else begin
        case (state_r)
          T_ADDR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s2_r};
              bit_cnt_r <= bit_cnt_r + 4'H1;
            end else if (scl_fall && bit_cnt_r == `BITS_PER_BYTE) begin
              if (addr_hit && sh_r[0] == `RW_READ) begin
                sda_oe_r <= 1'B1;
                o_read_event <= 1'B1;
                state_r <= T_ADDR_ACK;
              end else begin
                state_r <= T_IDLE;
              end
            end
          end
          T_ADDR_ACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'B0;
              scl_oe_r <= 1'B1;
              state_r <= T_ARM_WAIT;
            end
          end
          T_ARM_WAIT: begin
            if (armed_r) begin
              ptr_r <= i_tx_buffer_pointer;
              lim_r <= i_tx_byte_limit;
              cnt_r <= `CNT_RST;
              o_transmit_begun_event <= 1'B1;
              state_r <= T_FETCH;
            end
          end
          T_FETCH: begin
            // Clock held low while the byte is fetched
            if (!o_dma_req && cnt_r >= lim_r) begin
              sh_r <= i_overread_fill_byte;
              o_error_event <= 1'B1;
              state_r <= T_DRIVE;
            end else if (o_dma_req && i_dma_ack) begin
              sh_r <= i_dma_rdata;
              state_r <= T_DRIVE;
            end
          end
          T_DRIVE: begin
            sda_oe_r <= !sh_r[7];
            bit_cnt_r <= 4'H0;
            cnt_r <= (&cnt_r) ? cnt_r : cnt_r + CNT_W'(1);
            state_r <= T_SHIFT;
          end
          T_SHIFT: begin
            scl_oe_r <= 1'B0;
            if (scl_fall) begin
              bit_cnt_r <= bit_cnt_r + 4'H1;
              if (bit_cnt_r == `BITS_PER_BYTE - 4'H1) begin
                sda_oe_r <= 1'B0;
                state_r <= T_MACK;
              end else begin
                sh_r <= {sh_r[6:0], 1'B0};
                sda_oe_r <= !sh_r[6];
              end
            end
          end
          T_MACK: begin
            if (scl_rise) begin
              mack_r <= sda_s2_r;
            end else if (scl_fall) begin
              if (mack_r == `ACK_BIT) begin
                scl_oe_r <= 1'B1;
                state_r <= T_FETCH;
              end else begin
                state_r <= T_WAIT_STOP;
              end
            end
          end
          T_STOPPING: begin
            if (!o_dma_req) begin
              o_stopped_event <= 1'B1;
              state_r <= T_IDLE;
            end
          end
          default: begin
            scl_oe_r <= 1'B0;
            sda_oe_r <= 1'B0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Open-drain drive, level always low
  assign o_tx_bytes_sent_count = cnt_r;
  assign link.dev_scl_o = 1'B0;
  assign link.dev_sda_o = 1'B0;
  assign link.dev_scl_oe = scl_oe_r;
  assign link.dev_sda_oe = sda_oe_r;
endmodule

// [design/i2c_link_consts.svh]
`ifndef I2C_LINK_CONSTS_SVH
`define I2C_LINK_CONSTS_SVH
// Clock and link rates
`define CLK_RATE_KHZ 125000
`define SCL_RATE_STD_KHZ 100
`define SCL_RATE_FAST_KHZ 400
`define SCL_QTR_CYC(k) (`CLK_RATE_KHZ / (4 * (k)))
// Bus bit values
`define ACK_BIT 1'B0
`define NACK_BIT 1'B1
`define RW_READ 1'B1
// Address enable bits of the target configuration
`define CFG_ADDR0_BIT 0
`define CFG_ADDR1_BIT 1
// Field widths and reset values
`define ADDR_W 7
`define CNT_W 13
`define PTR_W 32
`define CNT_RST 13'H0000
`define PTR_RST 32'H0000_0000
`define BITS_PER_BYTE 4'H8
`endif

// [design/i2c_link_pkg.sv]
package i2c_link_pkg;
  // Target sequencer states
  typedef enum logic [3:0] {
    T_IDLE, T_ADDR, T_ADDR_ACK, T_ARM_WAIT, T_FETCH, T_DRIVE,
    T_SHIFT, T_MACK, T_WAIT_STOP, T_STOPPING
  } tgt_state_t;
  // Master sequencer states
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} mst_state_t;
endpackage

// [design/i2c_link_if.sv]
`timescale 1ns/1ps
interface i2c_link_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic mst_scl_o;
  logic mst_scl_oe;
  logic mst_sda_o;
  logic mst_sda_oe;
  logic scl;
  logic sda;
  // Wired-and of both open-drain ends with pull-up
  assign scl = !(dev_scl_oe && !dev_scl_o) && !(mst_scl_oe && !mst_scl_o);
  assign sda = !(dev_sda_oe && !dev_sda_o) && !(mst_sda_oe && !mst_sda_o);
  modport target (
    input scl, sda,
    output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe
  );
  modport master (
    input scl, sda,
    output mst_scl_o, mst_scl_oe, mst_sda_o, mst_sda_oe
  );
endinterface

// [design/i2c_bus_master.sv]
`timescale 1ns/1ps
`include "i2c_link_consts.svh"
module i2c_bus_master #(
  parameter int SCL_KHZ = `SCL_RATE_FAST_KHZ
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Command
  input wire logic i_cmd_start,
  input wire logic [`ADDR_W-1:0] i_cmd_addr,
  input wire logic [7:0] i_cmd_len,
  // Status and data
  output logic o_busy,
  output logic o_addr_acked,
  output logic o_done,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  // Link
  i2c_link_if.master link
);
  import i2c_link_pkg::*;

  localparam int QTR = `SCL_QTR_CYC(SCL_KHZ);
  generate
    if (QTR < 2 || QTR > 4096) begin : g_bad
      $error("i2c_bus_master: unsupported SCL rate");
    end
  endgenerate

  mst_state_t state_r;
  logic [12:0] qcnt_r;
  logic tick;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic addr_ph_r;
  logic [7:0] sh_r;
  logic [7:0] rem_r;
  logic ack_r;
  logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;
  logic scl_oe_r, sda_oe_r;

  // ****************************************
  // Synchronisers and quarter-bit divider
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      scl_s1_r <= 1'B1;
      scl_s2_r <= 1'B1;
      sda_s1_r <= 1'B1;
      sda_s2_r <= 1'B1;
    end else begin
      scl_s1_r <= link.scl;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= link.sda;
      sda_s2_r <= sda_s1_r;
    end
  end

  // One-cycle enable every quarter bit
  assign tick = (qcnt_r == 13'(QTR - 1));
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || state_r == M_IDLE || tick) begin
      qcnt_r <= 13'H0000;
    end else begin
      qcnt_r <= qcnt_r + 13'H0001;
    end
  end

  // ****************************************
  // Transfer sequencer
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_r <= M_IDLE;
      ph_r <= 2'H0;
      bit_r <= 4'H0;
      addr_ph_r <= 1'B0;
      sh_r <= 8'H00;
      rem_r <= 8'H00;
      ack_r <= `NACK_BIT;
      scl_oe_r <= 1'B0;
      sda_oe_r <= 1'B0;
      o_busy <= 1'B0;
      o_addr_acked <= 1'B0;
      o_done <= 1'B0;
      o_rd_valid <= 1'B0;
      o_rd_data <= 8'H00;
    end else begin
      o_done <= 1'B0;
      o_rd_valid <= 1'B0;
      case (state_r)
        M_IDLE: begin
          if (i_cmd_start) begin
            state_r <= M_START;
            ph_r <= 2'H0;
            sh_r <= {i_cmd_addr, `RW_READ};
            rem_r <= i_cmd_len;
            addr_ph_r <= 1'B1;
            o_busy <= 1'B1;
            o_addr_acked <= 1'B0;
          end
        end
        M_START: begin
          if (tick) begin
            ph_r <= ph_r + 2'H1;
            if (ph_r == 2'H0) begin
              sda_oe_r <= 1'B1;
            end else begin
              scl_oe_r <= 1'B1;
              bit_r <= 4'H0;
              ph_r <= 2'H0;
              state_r <= M_BIT;
            end
          end
        end
        M_BIT: begin
          if (tick) begin
            case (ph_r)
              2'H0: begin
                if (bit_r == `BITS_PER_BYTE) begin
                  // Ack our bytes, nack the last one
                  sda_oe_r <= !addr_ph_r && rem_r != 8'H01;
                end else begin
                  sda_oe_r <= addr_ph_r && !sh_r[7];
                end
                ph_r <= 2'H1;
              end
              2'H1: begin
                scl_oe_r <= 1'B0;
                ph_r <= 2'H2;
              end
              2'H2: begin
                // Wait while the target stretches
                if (scl_s2_r) begin
                  if (bit_r == `BITS_PER_BYTE) begin
                    ack_r <= sda_s2_r;
                  end else begin
                    sh_r <= {sh_r[6:0], sda_s2_r};
                  end
                  ph_r <= 2'H3;
                end
              end
              default: begin
                scl_oe_r <= 1'B1;
                ph_r <= 2'H0;
                bit_r <= bit_r + 4'H1;
                if (bit_r == `BITS_PER_BYTE - 4'H1 && !addr_ph_r) begin
                  o_rd_data <= sh_r;
                  o_rd_valid <= 1'B1;
                end
                if (bit_r == `BITS_PER_BYTE) begin
                  bit_r <= 4'H0;
                  if (addr_ph_r) begin
                    addr_ph_r <= 1'B0;
                    o_addr_acked <= (ack_r == `ACK_BIT);
                    if (ack_r != `ACK_BIT || rem_r == 8'H00) begin
                      state_r <= M_STOP;
                    end
                  end else begin
                    rem_r <= rem_r - 8'H01;
                    if (rem_r == 8'H01) begin
                      state_r <= M_STOP;
                    end
                  end
                end
              end
            endcase
          end
        end
        M_STOP: begin
          if (tick) begin
            ph_r <= ph_r + 2'H1;
            if (ph_r == 2'H0) begin
              sda_oe_r <= 1'B1;
            end else if (ph_r == 2'H1) begin
              scl_oe_r <= 1'B0;
            end else if (ph_r == 2'H2 && scl_s2_r) begin
              sda_oe_r <= 1'B0;
            end else if (ph_r == 2'H3) begin
              state_r <= M_IDLE;
              o_busy <= 1'B0;
              o_done <= 1'B1;
            end else begin
              ph_r <= ph_r;
            end
          end
        end
        default: begin
          state_r <= M_IDLE;
        end
      endcase
    end
  end

  // Open-drain drive, level always low
  assign link.mst_scl_o = 1'B0;
  assign link.mst_sda_o = 1'B0;
  assign link.mst_scl_oe = scl_oe_r;
  assign link.mst_sda_oe = sda_oe_r;
endmodule

// [tb/i2c_link_assertions.sv]
`timescale 1ns/1ps
module i2c_link_assertions (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Link signals
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic mst_scl_o,
  input wire logic mst_scl_oe,
  input wire logic mst_sda_o,
  input wire logic mst_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  // ****************************************
  // Bus conditions
  // ****************************************
  sequence start_seq;
    scl && $fell(sda);
  endsequence
  sequence stop_seq;
    scl && $rose(sda);
  endsequence

  // ****************************************
  // Checks
  // ****************************************
  chk_drain_only: assert property (
    (dev_scl_oe |-> !dev_scl_o) and (dev_sda_oe |-> !dev_sda_o) and
    (mst_scl_oe |-> !mst_scl_o) and (mst_sda_oe |-> !mst_sda_o))
    else $error("a line is driven high");
  chk_scl_release_setup: assert property ($fell(dev_scl_oe) |-> $stable(dev_sda_oe))
    else $error("target released clock as data changed");
  chk_sda_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target moved data with clock high");
  chk_stretch_low_only: assert property ($rose(dev_scl_oe) |-> !$past(scl))
    else $error("target pulled clock while it was high");
  chk_sda_hold_high: assert property (scl [*4] |-> $stable(dev_sda_oe))
    else $error("target changed data while clock high");
  chk_idle_in_address: assert property (start_seq |-> !dev_sda_oe [*8])
    else $error("target drives data right after start");
  chk_release_at_stop: assert property (stop_seq |=> (!dev_scl_oe && !dev_sda_oe) [*8])
    else $error("target holds bus after stop");
  chk_start_hold: assert property (start_seq |-> scl [*8])
    else $error("clock not held high after start");
  cover property (stop_seq);
endmodule

// [tb/i2c_target_read_response_tb.sv]
`timescale 1ns/1ps
module i2c_target_read_response_tb;
  import i2c_link_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic en, arm_t, stop_t, dma_ack, cmd_start;
  logic [1:0] addr_cfg;
  logic [6:0] adr0, adr1, cmd_addr;
  logic [31:0] ptr, dma_addr;
  logic [12:0] lim, sent_cnt;
  logic [7:0] fill, dma_rdata, cmd_len, rd_data;
  logic read_ev, begun_ev, stopped_ev, err_ev, dma_req, busy, addr_acked, done, rd_valid;
  logic [3:0] dma_wait;
  logic [7:0] rxq[$];
  int dma_delay, n_read, n_begun, n_stop, n_err, bad_count, compares;

  always #4 i_ref_clk = ~i_ref_clk;

  // ****************************************
  // Design ends and checker
  // ****************************************
  i2c_link_if link ();
  i2c_target_unit i_i2c_target_unit (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_enable(en),
    .i_addr_cfg(addr_cfg), .i_addr0(adr0), .i_addr1(adr1), .i_tx_buffer_pointer(ptr),
    .i_tx_byte_limit(lim), .i_overread_fill_byte(fill), .i_tx_arm_task(arm_t),
    .i_stop_task(stop_t), .o_read_event(read_ev), .o_transmit_begun_event(begun_ev),
    .o_stopped_event(stopped_ev), .o_error_event(err_ev), .o_tx_bytes_sent_count(sent_cnt),
    .o_dma_req(dma_req), .o_dma_addr(dma_addr), .i_dma_ack(dma_ack),
    .i_dma_rdata(dma_rdata), .link(link));
  i2c_bus_master #(.SCL_KHZ(400)) i_i2c_bus_master (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_cmd_start(cmd_start), .i_cmd_addr(cmd_addr), .i_cmd_len(cmd_len), .o_busy(busy),
    .o_addr_acked(addr_acked), .o_done(done), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .link(link));
  i2c_link_assertions i_i2c_link_assertions (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .dev_scl_o(link.dev_scl_o), .dev_scl_oe(link.dev_scl_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .mst_scl_o(link.mst_scl_o), .mst_scl_oe(link.mst_scl_oe),
    .mst_sda_o(link.mst_sda_o), .mst_sda_oe(link.mst_sda_oe), .scl(link.scl), .sda(link.sda));

  // Buffer contents seen by the reader
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ 8'HA5;
  endfunction

  // Memory side: ack after dma_delay cycles, data garbled outside ack
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      dma_ack <= 1'b0;
      dma_rdata <= 8'H00;
      dma_wait <= 4'H0;
    end else if (dma_req === 1'b1 && dma_ack !== 1'b1 && dma_wait == dma_delay[3:0]) begin
      dma_ack <= 1'b1;
      dma_rdata <= mem_byte(dma_addr);
      dma_wait <= 4'H0;
    end else begin
      dma_ack <= 1'b0;
      dma_rdata <= ~dma_rdata;
      if (dma_req === 1'b1 && dma_ack !== 1'b1) begin
        dma_wait <= dma_wait + 4'H1;
      end
    end
  end

  // Event and byte monitors
  always @(posedge i_ref_clk) begin
    if (read_ev === 1'b1) n_read++;
    if (begun_ev === 1'b1) n_begun++;
    if (stopped_ev === 1'b1) n_stop++;
    if (err_ev === 1'b1) n_err++;
    if (rd_valid === 1'b1) rxq.push_back(rd_data);
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_num(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_rx(input logic [31:0] base, input int n, input int l);
    logic [7:0] exp;
    check_num(16'(rxq.size()), 16'(n));
    for (int i = 0; i < n && i < rxq.size(); i++) begin
      exp = (i < l) ? mem_byte(base + 32'(i)) : fill;
      check8(rxq[i], exp);
    end
  endtask
  task automatic configure(input logic [1:0] c, input logic [31:0] p, input logic [12:0] l);
    @(posedge i_ref_clk);
    en <= 1'b0;
    @(posedge i_ref_clk);
    addr_cfg <= c;
    ptr <= p;
    lim <= l;
    @(posedge i_ref_clk);
    en <= 1'b1;
    n_read = 0;
    n_begun = 0;
    n_stop = 0;
    n_err = 0;
    rxq.delete();
  endtask
  task automatic fire_task(input bit do_stop);
    @(posedge i_ref_clk);
    if (do_stop) stop_t <= 1'b1;
    else arm_t <= 1'b1;
    @(posedge i_ref_clk);
    stop_t <= 1'b0;
    arm_t <= 1'b0;
  endtask
  task automatic master_read(input logic [6:0] a, input logic [7:0] n);
    @(posedge i_ref_clk);
    cmd_addr <= a;
    cmd_len <= n;
    cmd_start <= 1'b1;
    @(posedge i_ref_clk);
    cmd_start <= 1'b0;
  endtask
  task automatic wait_done;
    int k = 0;
    while (done !== 1'b1 && k < 40000) begin
      @(posedge i_ref_clk);
      k++;
    end
    if (k >= 40000) begin
      bad_count++;
      $display("mismatch at %0t: transfer never finished", $time);
    end
    repeat (4) @(posedge i_ref_clk);
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {en, arm_t, stop_t, cmd_start} = 4'H0;
    addr_cfg = 2'H0;
    {adr0, adr1, cmd_addr} = {7'H2C, 7'H51, 7'H00};
    {ptr, lim, fill, cmd_len} = {32'H0000_1000, 13'H0005, 8'HE7, 8'H00};
    {dma_delay, bad_count, compares} = 96'H0;
    repeat (10) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    // Armed before the read, first address, slow memory
    dma_delay = 6;
    configure(2'H3, 32'H0000_1000, 13'H0005);
    fire_task(0);
    master_read(7'H2C, 8'H03);
    wait_done;
    check_num({15'H0000, busy}, 16'H0000);
    check_num({15'H0000, addr_acked}, 16'H0001);
    check_num(16'(n_read), 16'H0001);
    check_num(16'(n_begun), 16'H0001);
    check_rx(32'H0000_1000, 3, 5);
    check_num({3'H0, sent_cnt}, 16'H0003);
    check_num(16'(n_err), 16'H0000);
    check_num(16'(n_stop), 16'H0001);
    // Second address only, stretch until armed, read past the limit
    dma_delay = 0;
    configure(2'H2, 32'H0000_2000, 13'H0002);
    master_read(7'H51, 8'H04);
    repeat (4000) @(posedge i_ref_clk);
    check_num(16'(n_begun), 16'H0000);
    check_num({15'H0000, link.scl}, 16'H0000);
    fire_task(0);
    repeat (50) @(posedge i_ref_clk);
    ptr <= 32'H0000_3000;
    wait_done;
    check_num(16'(n_begun), 16'H0001);
    check_rx(32'H0000_2000, 4, 2);
    check_num(16'(n_err), 16'H0002);
    check_num({3'H0, sent_cnt}, 16'H0004);
    // Disabled first address is ignored
    master_read(7'H2C, 8'H01);
    wait_done;
    check_num({15'H0000, addr_acked}, 16'H0000);
    check_num(16'(n_read), 16'H0001);
    // Stop task clears the armed flag, then aborts a stretched read
    configure(2'H1, 32'H0000_1000, 13'H0005);
    fire_task(0);
    fire_task(1);
    repeat (4) @(posedge i_ref_clk);
    check_num(16'(n_stop), 16'H0001);
    master_read(7'H2C, 8'H02);
    repeat (4000) @(posedge i_ref_clk);
    check_num(16'(n_begun), 16'H0000);
    fire_task(1);
    repeat (8) @(posedge i_ref_clk);
    check_num(16'(n_stop), 16'H0002);
    check_num({15'H0000, link.dev_scl_oe}, 16'H0000);
    wait_done;
    check_num(16'(n_begun), 16'H0000);
    give_verdict;
  end

  // Watchdog well beyond the expected 40000 cycles
  initial begin
    repeat (80000) @(posedge i_ref_clk);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule
